// *** core/hcp_pkg.sv ***
// Purpose: shared constants for the host command and data port
// Assumes: single clock domain, synchronous active-high reset
// Notes:   data path is 16 bits wide, command path 8 bits
package hcp_pkg;

    localparam int unsigned CMD_W       = 8;
    localparam int unsigned DATA_W      = 16;
    localparam int unsigned FIFO_DEPTH  = 16;
    localparam int unsigned FIFO_AW     = 4;
    localparam int unsigned SYNC_STAGES = 3;

    // values after reset
    localparam logic        RST_HOST_EMPTY = 1'b1;
    localparam logic        RST_ADP_FULL   = 1'b0;
    localparam logic [7:0]  RST_CMD_BYTE   = 8'h00;

    // direction bit encoding
    localparam logic        DIR_TO_ADAPTER = 1'b0;
    localparam logic        DIR_TO_HOST    = 1'b1;

endpackage

// *** core/hcp_stream_if.sv ***
// Purpose: valid/ready word stream between the port and its fifo
// Assumes: one clock domain
// Notes:   source drives valid and data, sink drives ready
`timescale 1ns/100ps
`default_nettype none
interface hcp_stream_if #(parameter int unsigned W = 16);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** core/hcp_fifo.sv ***
// Purpose: data fifo of the data register path
// Assumes: depth is a power of two
// Notes:   first-word output read combinationally from the array at the read pointer
`timescale 1ns/100ps
`default_nettype none
module hcp_fifo
    import hcp_pkg::*;
#(
    parameter int unsigned W  = 16,
    parameter int unsigned D  = 16,
    parameter int unsigned AW = 4
)(
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic flush,
    hcp_stream_if.snk in_s,
    hcp_stream_if.src out_s
);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0]   cnt_reg, cnt_next;
    logic          push, pop;

    // count is one bit wider than the pointers so that full can be told from empty
    assign in_s.ready  = (cnt_reg != (AW+1)'(D)) && !flush;
    assign out_s.valid = (cnt_reg != '0) && !flush;
    assign out_s.data  = mem[rd_reg];
    assign push = in_s.valid && in_s.ready;
    assign pop  = out_s.valid && out_s.ready;

    always_comb
    begin
        wr_next  = wr_reg + AW'(push);
        rd_next  = rd_reg + AW'(pop);
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        if (flush)
        begin
            wr_next  = '0;
            rd_next  = '0;
            cnt_next = '0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge clock)
    begin
        if (push)
        begin
            mem[wr_reg] <= in_s.data;
        end
    end

    a_fifo_no_over: assert property (@(posedge clock) disable iff (sys_rst)
        cnt_reg <= (AW+1)'(D)) else $error("fifo count above depth");
endmodule
`default_nettype wire

// *** core/hcp_sync.sv ***
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: input is asynchronous to clock
// Notes:   output changes once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module hcp_sync
    import hcp_pkg::*;
(
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic async_in,
    output var  logic sync_out
);
    logic s1_reg, s2_reg, s3_reg, out_reg, out_next;

    always_comb
    begin
        out_next = out_reg;
        if (s2_reg == s3_reg)
        begin
            out_next = s3_reg;
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            s1_reg  <= 1'b0;
            s2_reg  <= 1'b0;
            s3_reg  <= 1'b0;
            out_reg <= 1'b0;
        end
        else
        begin
            s1_reg  <= async_in;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign sync_out = out_reg;
endmodule
`default_nettype wire

// *** core/hcp_port.sv ***
// Purpose: host command and data port of a network adapter
// Assumes: host and on-board cpu strobes are one-cycle pulses on clock;
//          terminal count pins come from outside and are synchronised
// Notes:   fifo between data register faces, direction picks its source
//
// Notes on behaviour
// R1: command blocks move bytewise through command register
// R2: host waits for host_cmd_reg_empty before writing
// R3: adapter_cmd_reg_full flags a byte for host
// R4: host irq on adapter fill if enabled
// R5: host tc irq needs both enables
// R6: adapter may send unsolicited bytes anytime; the code drops a cpu write while adapter_cmd_reg_full is set
// R7: host command write interrupts on-board cpu
// R8: attention bit gives nmi to cpu
// R9: on-board dma channel 1 tc interrupts cpu
// R10: network controller irq is separate cpu source
// R11: host direction bit picks data register direction
// R12: data_port_ready gates each data register access
// R13: host programs dma then sets enables
// R14: on-board dma moves words through data register
// R15: empty/full flags follow writes and reads
`timescale 1ns/100ps
`default_nettype none
module hcp_port
    import hcp_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              sys_rst,
    // host command register
    input  wire logic              host_cmd_wr,
    input  wire logic [CMD_W-1:0]  host_cmd_wdata,
    input  wire logic              host_cmd_rd,
    output var  logic [CMD_W-1:0]  host_cmd_rdata,
    output var  logic              host_cmd_reg_empty,
    output var  logic              adapter_cmd_reg_full,
    // host control bits
    input  wire logic              cmd_irq_enable,
    input  wire logic              terminal_count_irq_enable,
    input  wire logic              host_dma_enable,
    input  wire logic              host_dir,
    input  wire logic              host_attention,
    input  wire logic              host_dma_tc,
    output var  logic              host_irq,
    // host data register
    input  wire logic              host_data_wr,
    input  wire logic [DATA_W-1:0] host_data_wdata,
    input  wire logic              host_data_rd,
    output var  logic [DATA_W-1:0] host_data_rdata,
    output logic                   data_port_ready,
    output logic                   host_dma_req,
    // on-board cpu command side
    input  wire logic              cpu_cmd_rd,
    output var  logic [CMD_W-1:0]  cpu_cmd_rdata,
    input  wire logic              cpu_cmd_wr,
    input  wire logic [CMD_W-1:0]  cpu_cmd_wdata,
    // on-board data side
    input  wire logic              adp_data_wr,
    input  wire logic [DATA_W-1:0] adp_data_wdata,
    input  wire logic              adp_data_rd,
    output var  logic [DATA_W-1:0] adp_data_rdata,
    output logic                   adp_data_ready,
    input  wire logic              adp_dma_tc,
    input  wire logic              net_ctrl_irq,
    // on-board cpu interrupts
    output var  logic              cpu_irq_cmd,
    output var  logic              cpu_irq_dma,
    output var  logic              cpu_irq_net,
    output var  logic              cpu_nmi
);

    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    logic host_tc_s, adp_tc_s, net_s;

    hcp_sync u_sync_htc (.clock(clock), .sys_rst(sys_rst), .async_in(host_dma_tc),
                         .sync_out(host_tc_s));
    hcp_sync u_sync_atc (.clock(clock), .sys_rst(sys_rst), .async_in(adp_dma_tc),
                         .sync_out(adp_tc_s));
    hcp_sync u_sync_net (.clock(clock), .sys_rst(sys_rst), .async_in(net_ctrl_irq),
                         .sync_out(net_s));

    // ---------------------------------------------------------------
    // command register, both directions
    // ---------------------------------------------------------------
    logic [CMD_W-1:0] h2a_reg, h2a_next, a2h_reg, a2h_next;
    logic             hempty_reg, hempty_next, afull_reg, afull_next;
    logic             cirq_reg, cirq_next, hci_reg, hci_next;

    always_comb
    begin
        h2a_next    = h2a_reg;
        a2h_next    = a2h_reg;
        hempty_next = hempty_reg;
        afull_next  = afull_reg;
        cirq_next   = cirq_reg;
        hci_next    = hci_reg;
        // cpu read frees the register; a host write in the same cycle is dropped unless it was already empty
        if (cpu_cmd_rd)
        begin
            hempty_next = 1'b1; // see R15
            cirq_next   = 1'b0;
        end
        // a write while full is dropped: host must wait for empty
        if (host_cmd_wr && hempty_reg)
        begin
            h2a_next    = host_cmd_wdata; // see R1
            hempty_next = 1'b0; // see R15
            cirq_next   = 1'b1; // see R7
        end
        if (host_cmd_rd)
        begin
            afull_next = 1'b0; // see R15
            hci_next   = 1'b0;
        end
        // responses and unsolicited requests use the same path
        if (cpu_cmd_wr && !afull_reg)
        begin
            a2h_next   = cpu_cmd_wdata; // see R6
            afull_next = 1'b1; // see R3
            hci_next   = 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            h2a_reg    <= RST_CMD_BYTE;
            a2h_reg    <= RST_CMD_BYTE;
            hempty_reg <= RST_HOST_EMPTY;
            afull_reg  <= RST_ADP_FULL;
            cirq_reg   <= 1'b0;
            hci_reg    <= 1'b0;
        end
        else
        begin
            h2a_reg    <= h2a_next;
            a2h_reg    <= a2h_next;
            hempty_reg <= hempty_next;
            afull_reg  <= afull_next;
            cirq_reg   <= cirq_next;
            hci_reg    <= hci_next;
        end
    end

    assign host_cmd_rdata       = a2h_reg;
    assign cpu_cmd_rdata        = h2a_reg;
    assign host_cmd_reg_empty   = hempty_reg; // see R2
    assign adapter_cmd_reg_full = afull_reg;
    assign cpu_irq_cmd          = cirq_reg;

    // ---------------------------------------------------------------
    // interrupts
    // ---------------------------------------------------------------
    logic htc_reg, htc_next, atc_reg, atc_next, atc_d_reg, htc_d_reg;
    logic nmi_reg, nmi_next, net_reg, hirq_reg, hirq_next;

    always_comb
    begin
        htc_next = htc_reg;
        atc_next = atc_reg;
        if (!host_dma_enable)
        begin
            htc_next = 1'b0;
        end
        if (host_tc_s && !htc_d_reg)
        begin
            htc_next = 1'b1;
        end
        if (adp_data_rd || adp_data_wr)
        begin
            atc_next = 1'b0;
        end
        if (adp_tc_s && !atc_d_reg)
        begin
            atc_next = 1'b1; // see R9
        end
        nmi_next  = host_attention; // see R8
        hirq_next = (cmd_irq_enable && hci_next) // see R4
            || (terminal_count_irq_enable && host_dma_enable && htc_next); // see R5
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            htc_reg   <= 1'b0;
            atc_reg   <= 1'b0;
            htc_d_reg <= 1'b0;
            atc_d_reg <= 1'b0;
            nmi_reg   <= 1'b0;
            net_reg   <= 1'b0;
            hirq_reg  <= 1'b0;
        end
        else
        begin
            htc_reg   <= htc_next;
            atc_reg   <= atc_next;
            htc_d_reg <= host_tc_s;
            atc_d_reg <= adp_tc_s;
            nmi_reg   <= nmi_next;
            net_reg   <= net_s; // see R10
            hirq_reg  <= hirq_next;
        end
    end

    assign host_irq    = hirq_reg;
    assign cpu_irq_dma = atc_reg;
    assign cpu_irq_net = net_reg;
    assign cpu_nmi     = nmi_reg;

    // ---------------------------------------------------------------
    // data register path through the fifo
    // ---------------------------------------------------------------
    hcp_stream_if #(.W(DATA_W)) fin ();
    hcp_stream_if #(.W(DATA_W)) fout ();
    logic             dir_reg, flush;
    logic [DATA_W-1:0] hrd_reg, hrd_next, ard_reg, ard_next;

    assign flush = (dir_reg != host_dir);
    // host direction chooses which face fills the fifo
    assign fin.valid = (host_dir == DIR_TO_ADAPTER) ? host_data_wr : adp_data_wr; // see R11
    assign fin.data  = (host_dir == DIR_TO_ADAPTER) ? host_data_wdata : adp_data_wdata;
    assign fout.ready = (host_dir == DIR_TO_ADAPTER) ? adp_data_rd : host_data_rd;

    // ready means a write has room or a read has data
    assign data_port_ready = (host_dir == DIR_TO_ADAPTER) ? fin.ready : fout.valid; // see R12
    assign adp_data_ready  = (host_dir == DIR_TO_ADAPTER) ? fout.valid : fin.ready; // see R14
    assign host_dma_req    = host_dma_enable && data_port_ready; // see R13

    always_comb
    begin
        hrd_next = hrd_reg;
        ard_next = ard_reg;
        if (fout.valid && fout.ready && host_dir == DIR_TO_HOST)
        begin
            hrd_next = fout.data;
        end
        if (fout.valid && fout.ready && host_dir == DIR_TO_ADAPTER)
        begin
            ard_next = fout.data; // see R14
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            dir_reg <= DIR_TO_ADAPTER;
            hrd_reg <= '0;
            ard_reg <= '0;
        end
        else
        begin
            dir_reg <= host_dir;
            hrd_reg <= hrd_next;
            ard_reg <= ard_next;
        end
    end

    assign host_data_rdata = hrd_reg;
    assign adp_data_rdata  = ard_reg;

    hcp_fifo #(.W(DATA_W), .D(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
        .clock   (clock),
        .sys_rst (sys_rst),
        .flush   (flush),
        .in_s    (fin),
        .out_s   (fout)
    );

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_host_wr_empty: assert property (@(posedge clock) disable iff (sys_rst) // see R15
        host_cmd_wr && hempty_reg |=> !host_cmd_reg_empty && cpu_irq_cmd)
        else $error("host write did not fill register");
    a_cpu_rd_free: assert property (@(posedge clock) disable iff (sys_rst) // see R15
        cpu_cmd_rd && !host_cmd_wr |=> host_cmd_reg_empty)
        else $error("cpu read did not free register");
    a_cmd_byte: assert property (@(posedge clock) disable iff (sys_rst) // see R1
        host_cmd_wr && hempty_reg |=> cpu_cmd_rdata == $past(host_cmd_wdata))
        else $error("command byte lost");
    a_adp_fill: assert property (@(posedge clock) disable iff (sys_rst) // see R3
        cpu_cmd_wr && !afull_reg && !host_cmd_rd |=> adapter_cmd_reg_full)
        else $error("full flag not set");
    a_cmd_irq: assert property (@(posedge clock) disable iff (sys_rst) // see R4
        cpu_cmd_wr && !afull_reg && cmd_irq_enable |=> host_irq)
        else $error("command interrupt missing");
    a_tc_gate: assert property (@(posedge clock) disable iff (sys_rst) // see R5
        !terminal_count_irq_enable && !$past(terminal_count_irq_enable) && !hci_reg
        |-> !host_irq)
        else $error("tc interrupt without enable");
    a_nmi_follow: assert property (@(posedge clock) disable iff (sys_rst) // see R8
        host_attention |=> cpu_nmi)
        else $error("attention did not raise nmi");
    a_ready_wr: assert property (@(posedge clock) disable iff (sys_rst) // see R12
        host_dir == DIR_TO_ADAPTER && !flush && host_data_wr && data_port_ready
        |=> adp_data_ready || flush)
        else $error("accepted host word not offered to adapter");
endmodule
`default_nettype wire

// *** testbench/hcp_host_model.sv ***
// Purpose: host cpu side of the port, command and data strobes
// Assumes: strobes are one-cycle pulses launched 1 ns after the edge
// Notes:   each access waits for its flag, bounded to 50 cycles
`timescale 1ns/100ps
`default_nettype none
module hcp_host_model
    import hcp_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              host_cmd_reg_empty,
    input  wire logic              adapter_cmd_reg_full,
    input  wire logic              data_port_ready,
    output logic                   host_cmd_wr,
    output logic [CMD_W-1:0]       host_cmd_wdata,
    output logic                   host_cmd_rd,
    output logic                   host_data_wr,
    output logic [DATA_W-1:0]      host_data_wdata,
    output logic                   host_data_rd
);
    // accesses issued after the flag wait ran out
    int stalls = 0;

    initial
    begin
        {host_cmd_wr, host_cmd_rd, host_data_wr, host_data_rd} = 4'h0;
        host_cmd_wdata  = 8'h00;
        host_data_wdata = 16'h0000;
    end

    function automatic logic flag(input int kind);
        if (kind == 0)
            return host_cmd_reg_empty;
        if (kind == 1)
            return adapter_cmd_reg_full;
        return data_port_ready;
    endfunction

    // kind: 0 command write, 1 command read, 2 data write, 3 data read
    task automatic access(input int kind, input logic [15:0] v);
        int n;
        n = 0;
        do
        begin
            @(posedge clock);
            #1;
            n++;
        end
        while (flag(kind) !== 1'b1 && n < 50);
        if (flag(kind) !== 1'b1)
        begin
            stalls++;
        end
        host_cmd_wr     = (kind == 0);
        host_cmd_rd     = (kind == 1);
        host_data_wr    = (kind == 2);
        host_data_rd    = (kind == 3);
        host_cmd_wdata  = v[7:0];
        host_data_wdata = v;
        @(posedge clock);
        #1;
        {host_cmd_wr, host_cmd_rd, host_data_wr, host_data_rd} = 4'h0;
        // released data lines do not keep the last value
        host_cmd_wdata  = ~v[7:0];
        host_data_wdata = ~v;
    endtask
endmodule
`default_nettype wire

// *** testbench/hcp_port_bench.sv ***
// Purpose: self-checking bench of the host command and data port
// Assumes: inputs change 1 ns after the rising edge
// Notes:   expected words are kept in a queue, values from an lfsr
`timescale 1ns/100ps
`default_nettype none
module hcp_port_bench
    import hcp_pkg::*;
;
    logic clock = 1'b0, sys_rst = 1'b1;
    logic host_cmd_wr, host_cmd_rd, host_data_wr, host_data_rd;
    logic [7:0] host_cmd_wdata, host_cmd_rdata, cpu_cmd_rdata, cpu_cmd_wdata;
    logic [15:0] host_data_wdata, host_data_rdata, adp_data_wdata, adp_data_rdata;
    logic host_cmd_reg_empty, adapter_cmd_reg_full, data_port_ready, host_dma_req;
    logic cmd_irq_enable = 0, terminal_count_irq_enable = 0, host_dma_enable = 0;
    logic host_dir = 0, host_attention = 0, host_dma_tc = 0, host_irq;
    logic cpu_cmd_rd = 0, cpu_cmd_wr = 0, adp_data_wr = 0, adp_data_rd = 0;
    logic adp_data_ready, adp_dma_tc = 0, net_ctrl_irq = 0;
    logic cpu_irq_cmd, cpu_irq_dma, cpu_irq_net, cpu_nmi;
    logic [15:0] rnd = 16'h0016;
    logic [15:0] q[$];
    int bad_count = 0, num_checks = 0;

    always #2.5 clock = ~clock;

    hcp_port uut (.clock(clock), .sys_rst(sys_rst), .host_cmd_wr(host_cmd_wr),
        .host_cmd_wdata(host_cmd_wdata), .host_cmd_rd(host_cmd_rd),
        .host_cmd_rdata(host_cmd_rdata), .host_cmd_reg_empty(host_cmd_reg_empty),
        .adapter_cmd_reg_full(adapter_cmd_reg_full), .cmd_irq_enable(cmd_irq_enable),
        .terminal_count_irq_enable(terminal_count_irq_enable),
        .host_dma_enable(host_dma_enable), .host_dir(host_dir),
        .host_attention(host_attention), .host_dma_tc(host_dma_tc), .host_irq(host_irq),
        .host_data_wr(host_data_wr), .host_data_wdata(host_data_wdata),
        .host_data_rd(host_data_rd), .host_data_rdata(host_data_rdata),
        .data_port_ready(data_port_ready), .host_dma_req(host_dma_req),
        .cpu_cmd_rd(cpu_cmd_rd), .cpu_cmd_rdata(cpu_cmd_rdata), .cpu_cmd_wr(cpu_cmd_wr),
        .cpu_cmd_wdata(cpu_cmd_wdata), .adp_data_wr(adp_data_wr),
        .adp_data_wdata(adp_data_wdata), .adp_data_rd(adp_data_rd),
        .adp_data_rdata(adp_data_rdata), .adp_data_ready(adp_data_ready),
        .adp_dma_tc(adp_dma_tc), .net_ctrl_irq(net_ctrl_irq), .cpu_irq_cmd(cpu_irq_cmd),
        .cpu_irq_dma(cpu_irq_dma), .cpu_irq_net(cpu_irq_net), .cpu_nmi(cpu_nmi));

    hcp_host_model host (.clock(clock), .host_cmd_reg_empty(host_cmd_reg_empty),
        .adapter_cmd_reg_full(adapter_cmd_reg_full), .data_port_ready(data_port_ready),
        .host_cmd_wr(host_cmd_wr), .host_cmd_wdata(host_cmd_wdata),
        .host_cmd_rd(host_cmd_rd), .host_data_wr(host_data_wr),
        .host_data_wdata(host_data_wdata), .host_data_rd(host_data_rd));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic chk1(input string what, input logic seen, input logic exp);
        check(what, {15'h0000, seen}, {15'h0000, exp});
    endtask

    // kind: 0 cpu command write, 1 cpu command read, 2 data write, 3 data read
    task automatic adp_pulse(input int kind, input logic [15:0] v);
        @(posedge clock);
        #1;
        cpu_cmd_wr     = (kind == 0);
        cpu_cmd_rd     = (kind == 1);
        adp_data_wr    = (kind == 2);
        adp_data_rd    = (kind == 3);
        cpu_cmd_wdata  = v[7:0];
        adp_data_wdata = v;
        @(posedge clock);
        #1;
        {cpu_cmd_wr, cpu_cmd_rd, adp_data_wr, adp_data_rd} = 4'h0;
        cpu_cmd_wdata  = ~v[7:0];
        adp_data_wdata = ~v;
    endtask

    task automatic wait8();
        repeat (8) @(posedge clock);
        #1;
    endtask

    task automatic end_of_test();
        if (bad_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clock);
        bad_count++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [15:0] a;
        cpu_cmd_wdata  = 8'h00;
        adp_data_wdata = 16'h0000;
        repeat (2) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        chk1("empty", host_cmd_reg_empty, 1'b1);
        chk1("full", adapter_cmd_reg_full, 1'b0);
        chk1("host_irq", host_irq, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            rnd = lfsr_next(rnd);
            host.access(0, rnd);
            chk1("empty", host_cmd_reg_empty, 1'b0);
            chk1("cpu_irq_cmd", cpu_irq_cmd, 1'b1);
            check("cpu_cmd_rdata", {8'h00, cpu_cmd_rdata}, {8'h00, rnd[7:0]});
            adp_pulse(1, 16'h0000);
            chk1("empty", host_cmd_reg_empty, 1'b1);
            chk1("cpu_irq_cmd", cpu_irq_cmd, 1'b0);
        end
        cmd_irq_enable = 1'b1;
        rnd = lfsr_next(rnd);
        a = rnd;
        adp_pulse(0, a);
        chk1("full", adapter_cmd_reg_full, 1'b1);
        chk1("host_irq", host_irq, 1'b1);
        adp_pulse(0, ~a);
        check("host_cmd_rdata", {8'h00, host_cmd_rdata}, {8'h00, a[7:0]});
        host.access(1, 16'h0000);
        chk1("full", adapter_cmd_reg_full, 1'b0);
        chk1("host_irq", host_irq, 1'b0);
        cmd_irq_enable = 1'b0;
        adp_pulse(0, ~a);
        chk1("host_irq", host_irq, 1'b0);
        check("host_cmd_rdata", {8'h00, host_cmd_rdata}, {8'h00, ~a[7:0]});
        host.access(1, 16'h0000);
        terminal_count_irq_enable = 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            host_dma_enable = k[0];
            host_dma_tc = 1'b1;
            wait8();
            chk1("host_irq", host_irq, k[0]);
            host_dma_tc = 1'b0;
            wait8();
        end
        host_dma_enable = 1'b0;
        wait8();
        chk1("host_irq", host_irq, 1'b0);
        host_attention = 1'b1;
        @(posedge clock);
        #1;
        chk1("cpu_nmi", cpu_nmi, 1'b1);
        host_attention = 1'b0;
        adp_dma_tc = 1'b1;
        net_ctrl_irq = 1'b1;
        wait8();
        chk1("cpu_nmi", cpu_nmi, 1'b0);
        chk1("cpu_irq_dma", cpu_irq_dma, 1'b1);
        chk1("cpu_irq_net", cpu_irq_net, 1'b1);
        adp_dma_tc = 1'b0;
        net_ctrl_irq = 1'b0;
        wait8();
        chk1("cpu_irq_net", cpu_irq_net, 1'b0);
        chk1("cpu_irq_dma", cpu_irq_dma, 1'b1);
        host_dma_enable = 1'b1;
        #1;
        chk1("host_dma_req", host_dma_req, 1'b1);
        for (int i = 0; i < 16; i++)
        begin
            rnd = lfsr_next(rnd);
            q.push_back(rnd);
            host.access(2, rnd);
        end
        chk1("data_port_ready", data_port_ready, 1'b0);
        chk1("host_dma_req", host_dma_req, 1'b0);
        for (int i = 0; i < 16; i++)
        begin
            chk1("adp_data_ready", adp_data_ready, 1'b1);
            adp_pulse(3, 16'h0000);
            check("adp_data_rdata", adp_data_rdata, q.pop_front());
            if (i == 0)
                chk1("cpu_irq_dma", cpu_irq_dma, 1'b0);
            rnd = lfsr_next(rnd);
            repeat (rnd[1:0]) @(posedge clock);
            #1;
        end
        chk1("adp_data_ready", adp_data_ready, 1'b0);
        host_dir = DIR_TO_HOST;
        repeat (3) @(posedge clock);
        #1;
        for (int i = 0; i < 4; i++)
        begin
            rnd = lfsr_next(rnd);
            q.push_back(rnd);
            chk1("adp_data_ready", adp_data_ready, 1'b1);
            adp_pulse(2, rnd);
        end
        for (int i = 0; i < 4; i++)
        begin
            host.access(3, 16'h0000);
            check("host_data_rdata", host_data_rdata, q.pop_front());
        end
        check("host stalls", 16'(host.stalls), 16'h0000);
        end_of_test();
    end
endmodule
`default_nettype wire
